//--- common/hdc_pkg.sv
// Types shared by the haptic drive control block
package hdc_pkg;
  typedef struct packed {
    logic       enable;
    logic       od_enable;
    logic       od_polarity;
    logic       motor_type;
    logic [1:0] reserved;
    logic [1:0] pwm_div;
  } hdc_drive_ctl_t;

  typedef struct packed {
    logic [2:0] in_res;
    logic [2:0] vreg;
    logic [1:0] reserved;
  } hdc_level_ctl_t;

  typedef struct packed {
    logic       drive_on;
    logic       overdrive_enable;
    logic       overdrive_polarity;
    logic       motor_type_select;
    logic [2:0] in_res_code;
    logic [2:0] regulator_voltage_code;
    logic       regulator_code_valid;
  } hdc_drive_out_t;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_PTR   = 9'h008,
    ST_ACK_P = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_ACK_R = 9'h100
  } hdc_state_t;
endpackage : hdc_pkg

//--- common/hdc_regs.svh
// Register map, reset values, write masks and divider constants of the haptic drive control block
`ifndef HDC_REGS_SVH
`define HDC_REGS_SVH
`define HDC_DEV_ADDR        7'h06
`define HDC_OFS_DRIVE       8'h20
`define HDC_OFS_LEVEL       8'h21
`define HDC_OFS_STATUS      8'h22
`define HDC_RST_DRIVE       8'h90
`define HDC_RST_LEVEL       8'h2C
`define HDC_RST_STATUS      8'h0E
`define HDC_MASK_DRIVE      8'hF3
`define HDC_MASK_LEVEL      8'hFC
`define HDC_VREG_UNDEF      3'h7
`define HDC_HALF_DIV128     8'h3F
`define HDC_HALF_DIV256     8'h7F
`define HDC_HALF_DIV512     8'hFF
`endif

//--- hw/hdc_regs_top.sv
// Serial-bus register bank and drive control of the haptic motor driver
`timescale 1ns/1ps
`include "hdc_regs.svh"

module hdc_regs_top import hdc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `HDC_DEV_ADDR
) (
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     reset,
  // Serial bus, open drain data
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output logic          sda_out,
  output logic          sda_oe_n,
  // Pins and analog monitors
  input  wire logic     motor_enable_pin,
  input  wire logic     pwm_in,
  input  wire logic     supply_above_lockout,
  input  wire logic     regulator_above_70pct,
  input  wire logic     temp_above_trip,
  input  wire logic     temp_below_release,
  // Drive stage controls
  output hdc_drive_out_t drive_out,
  output logic          pwm_div_out
);

  // General call address would answer every broadcast
  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("General call address cannot be a slave address");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one only feeds stage two
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic             scl_p_q;
  logic             sda_p_q;
  logic             pwm_p_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q  <= 8'h03;
      sync_q  <= 8'h03;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      pwm_p_q <= 1'b0;
    end else begin
      meta_q  <= {temp_below_release, temp_above_trip, regulator_above_70pct,
                  supply_above_lockout, pwm_in, motor_enable_pin, sda_in, scl_in};
      sync_q  <= meta_q;
      scl_p_q <= sync_q[0];
      sda_p_q <= sync_q[1];
      pwm_p_q <= sync_q[3];
    end
  end

  logic scl_s;
  logic sda_s;
  logic men_s;
  logic pwm_s;
  logic vdd_s;
  logic vreg_s;
  logic hot_s;
  logic cool_s;
  assign {cool_s, hot_s, vreg_s, vdd_s, pwm_s, men_s, sda_s, scl_s} = sync_q;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  hdc_drive_ctl_t ctl0_q, ctl0_d;
  hdc_level_ctl_t ctl1_q, ctl1_d;
  logic [7:0]     stat_q, stat_d;
  logic           trip_q, trip_d;
  logic           wr_en;
  logic [7:0]     wr_ptr;
  logic [7:0]     wr_data;
  logic [7:0]     rd_ptr;
  logic [7:0]     rd_data;

  // Register read mux, unmapped offsets read zero
  always_comb begin
    if (rd_ptr == `HDC_OFS_DRIVE) begin
      rd_data = ctl0_q & `HDC_MASK_DRIVE;
    end else if (rd_ptr == `HDC_OFS_LEVEL) begin
      rd_data = ctl1_q & `HDC_MASK_LEVEL;
    end else if (rd_ptr == `HDC_OFS_STATUS) begin
      rd_data = stat_q;
    end else begin
      rd_data = 8'h00;
    end
  end

  always_comb begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    if (wr_en && wr_ptr == `HDC_OFS_DRIVE) begin
      ctl0_d = wr_data & `HDC_MASK_DRIVE;
    end else if (wr_en && wr_ptr == `HDC_OFS_LEVEL) begin
      ctl1_d = wr_data & `HDC_MASK_LEVEL;
    end
    // Status offset takes no write at all
    // Trip wins over release; hysteresis lives in the two comparators
    if (hot_s) begin
      trip_d = 1'b1;
    end else if (cool_s) begin
      trip_d = 1'b0;
    end else begin
      trip_d = trip_q;
    end
    stat_d = {4'h0, vdd_s, vreg_s, ~trip_q, 1'b0};
  end

  // Thermal trip never touches the control registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl0_q <= `HDC_RST_DRIVE;
      ctl1_q <= `HDC_RST_LEVEL;
      stat_q <= `HDC_RST_STATUS;
      trip_q <= 1'b0;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      stat_q <= stat_d;
      trip_q <= trip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  hdc_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic       pull_q, pull_d;

  assign wr_ptr  = ptr_q;
  assign wr_data = sr_q;
  // Registered pointer keeps the read mux out of the state loop
  assign rd_ptr  = ptr_q;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sr_d   = sr_q;
    tx_d   = tx_q;
    ptr_d  = ptr_q;
    pull_d = pull_q;
    wr_en  = 1'b0;
    if (bus_start) begin
      st_d   = ST_ADDR;
      cnt_d  = 4'h0;
      pull_d = 1'b0;
    end else if (bus_stop) begin
      st_d   = ST_IDLE;
      pull_d = 1'b0;
    end else begin
      if (scl_rise && cnt_q != 4'h8 &&
          (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDATA || st_q == ST_RDATA)) begin
        sr_d  = {sr_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end
      case (st_q)
        ST_ADDR: begin
          if (scl_fall && cnt_q == 4'h8) begin
            if (sr_q[7:1] == DEV_ADDR) begin
              st_d   = ST_ACK_A;
              pull_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (sr_q[0]) begin
              st_d   = ST_RDATA;
              tx_d   = rd_data;
              pull_d = ~rd_data[7];
            end else begin
              st_d   = ST_PTR;
              pull_d = 1'b0;
            end
          end
        end
        ST_PTR: begin
          if (scl_fall && cnt_q == 4'h8) begin
            ptr_d  = sr_q;
            st_d   = ST_ACK_P;
            pull_d = 1'b1;
          end
        end
        ST_ACK_P, ST_ACK_W: begin
          if (scl_fall) begin
            st_d   = ST_WDATA;
            cnt_d  = 4'h0;
            pull_d = 1'b0;
          end
        end
        ST_WDATA: begin
          if (scl_fall && cnt_q == 4'h8) begin
            wr_en  = 1'b1;
            ptr_d  = ptr_q + 8'h01;
            st_d   = ST_ACK_W;
            pull_d = 1'b1;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              st_d   = ST_ACK_R;
              pull_d = 1'b0;
            end else begin
              tx_d   = {tx_q[6:0], 1'b0};
              pull_d = ~tx_q[6];
            end
          end
        end
        ST_ACK_R: begin
          // Master NACK ends the read; stop or start follows
          if (scl_rise) begin
            if (sda_s) begin
              st_d = ST_IDLE;
            end else begin
              ptr_d = ptr_q + 8'h01;
            end
          end else if (scl_fall) begin
            st_d   = ST_RDATA;
            cnt_d  = 4'h0;
            tx_d   = rd_data;
            pull_d = ~rd_data[7];
          end
        end
        default: begin
          st_d   = ST_IDLE;
          pull_d = 1'b0;
        end
      endcase
    end
  end

  // Pointer is kept between transfers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 4'h0;
      sr_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= 8'h00;
      pull_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sr_q   <= sr_d;
      tx_q   <= tx_d;
      ptr_q  <= ptr_d;
      pull_q <= pull_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM divider: toggles every half ratio of input rising edges
  logic [7:0]     div_q, div_d;
  logic [7:0]     half;
  logic           pwm_o_q, pwm_o_d;
  logic           pwm_rise;
  hdc_drive_out_t dout_q, dout_d;
  logic           sda_o_q;
  logic           oe_n_q, oe_n_d;

  assign pwm_rise = pwm_s & ~pwm_p_q;

  always_comb begin
    case (ctl0_q.pwm_div)
      2'h1:    half = `HDC_HALF_DIV128;
      2'h2:    half = `HDC_HALF_DIV256;
      default: half = `HDC_HALF_DIV512;
    endcase
    div_d   = div_q;
    pwm_o_d = pwm_o_q;
    // Eccentric-mass mode and ratio 1 pass the input straight on
    if (ctl0_q.motor_type || ctl0_q.pwm_div == 2'h0) begin
      div_d   = 8'h00;
      pwm_o_d = pwm_s;
    end else if (pwm_rise) begin
      if (div_q >= half) begin
        div_d   = 8'h00;
        pwm_o_d = ~pwm_o_q;
      end else begin
        div_d = div_q + 8'h01;
      end
    end
    dout_d.drive_on = ctl0_q.enable & men_s & ~trip_q;
    dout_d.overdrive_enable   = ctl0_q.od_enable & ctl0_q.motor_type;
    dout_d.overdrive_polarity = ctl0_q.od_polarity & ctl0_q.motor_type;
    dout_d.motor_type_select  = ctl0_q.motor_type;
    // Resistor code only retunes the network; gain held at one
    dout_d.in_res_code            = ctl1_q.in_res;
    dout_d.regulator_voltage_code = ctl1_q.vreg;
    dout_d.regulator_code_valid   = ctl1_q.vreg != `HDC_VREG_UNDEF;
    oe_n_d = ~pull_d;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q   <= 8'h00;
      pwm_o_q <= 1'b0;
      dout_q  <= '0;
      sda_o_q <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      div_q   <= div_d;
      pwm_o_q <= pwm_o_d;
      dout_q  <= dout_d;
      sda_o_q <= 1'b0;
      oe_n_q  <= oe_n_d;
    end
  end

  assign drive_out   = dout_q;
  assign pwm_div_out = pwm_o_q;
  assign sda_out     = sda_o_q;
  assign sda_oe_n    = oe_n_q;

endmodule : hdc_regs_top

//--- testbench/hdc_host_model.sv
// Serial-bus host model for the haptic drive register bank
`timescale 1ns/1ps
module hdc_host_model (
  // Clock
  input  wire logic sys_clk,
  // Bus, data released while sda_rel high
  input  wire logic sda_wire,
  output logic      scl_pin,
  output logic      sda_rel
);
  logic [7:0] dat [4];
  logic       addr_ack;
  logic       ack_seen;
  initial begin
    scl_pin = 1'b1;
    sda_rel = 1'b1;
  end
  // Half bit of 8 clocks; the device needs 5
  task automatic hold();
    repeat (8) @(negedge sys_clk);
  endtask : hold
  // Data moves one clock after the fall, never with it
  task automatic xbit(input logic b, output logic s);
    @(negedge sys_clk);
    sda_rel = b;
    hold();
    scl_pin = 1'b1;
    hold();
    s = sda_wire;
    scl_pin = 1'b0;
  endtask : xbit
  task automatic start();
    @(negedge sys_clk);
    sda_rel = 1'b1;
    hold();
    scl_pin = 1'b1;
    hold();
    sda_rel = 1'b0;
    hold();
    scl_pin = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge sys_clk);
    sda_rel = 1'b0;
    hold();
    scl_pin = 1'b1;
    hold();
    sda_rel = 1'b1;
    hold();
  endtask : stop
  task automatic xbyte(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], s);
      rx[i] = s;
    end
    xbit(last, ack_seen);
  endtask : xbyte
  // Pointer byte, then data; a read turns round through a repeated start
  task automatic transfer(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic rd, input int n);
    logic [7:0] rx;
    start();
    xbyte({dev, 1'b0}, 1'b1, rx);
    addr_ack = ack_seen;
    xbyte(ptr, 1'b1, rx);
    if (rd) begin
      start();
      xbyte({dev, 1'b1}, 1'b1, rx);
    end
    for (int i = 0; i < n; i++) begin
      xbyte(rd ? 8'hFF : dat[i], rd ? (i == n - 1) : 1'b1, rx);
      if (rd) begin
        dat[i] = rx;
      end
    end
    stop();
  endtask : transfer
endmodule : hdc_host_model

//--- testbench/hdc_regs_top_asserts.sv
// Port-level assertions for the haptic drive control register bank
`timescale 1ns/1ps
module hdc_regs_asserts import hdc_pkg::*; (
  // Clock and reset
  input wire logic           sys_clk,
  input wire logic           reset,
  // Serial bus
  input wire logic           scl_in,
  input wire logic           sda_in,
  input wire logic           sda_out,
  input wire logic           sda_oe_n,
  // Pins and monitors
  input wire logic           motor_enable_pin,
  input wire logic           pwm_in,
  input wire logic           supply_above_lockout,
  input wire logic           regulator_above_70pct,
  input wire logic           temp_above_trip,
  input wire logic           temp_below_release,
  // Drive stage
  input wire hdc_drive_out_t drive_out,
  input wire logic           pwm_div_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property (
    $fell(reset) |-> drive_out == '0 && !pwm_div_out && sda_oe_n)
    else $error("outputs not idle after reset");
  chk_default_levels: assert property (
    $fell(reset) |-> ##3 drive_out.motor_type_select && drive_out.in_res_code == 3'h1
      && drive_out.regulator_voltage_code == 3'h3)
    else $error("drive levels not at defaults");
  chk_od_erm_only: assert property (
    drive_out.overdrive_enable || drive_out.overdrive_polarity |-> drive_out.motor_type_select)
    else $error("over-drive active outside eccentric mode");
  chk_vreg_undef: assert property (
    drive_out.regulator_code_valid |-> drive_out.regulator_voltage_code != 3'h7)
    else $error("undefined regulator code flagged valid");
  chk_pin_gates: assert property (
    !motor_enable_pin [*5] |=> !drive_out.drive_on)
    else $error("drive on with motor pin low");
  chk_trip_off: assert property (
    temp_above_trip [*5] |=> !drive_out.drive_on)
    else $error("drive on during thermal trip");
  chk_erm_follow: assert property (
    drive_out.motor_type_select [*6] |-> pwm_div_out == $past(pwm_in, 3))
    else $error("pwm not passed through in eccentric mode");
  chk_ack_scl_low: assert property (
    $fell(sda_oe_n) |-> !scl_in)
    else $error("data pulled low while clock high");
  chk_never_high: assert property (
    !sda_oe_n |-> !sda_out)
    else $error("data line driven high");
endmodule : hdc_regs_asserts

bind hdc_regs_top hdc_regs_asserts chk_u (
  .sys_clk(sys_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .motor_enable_pin(motor_enable_pin), .pwm_in(pwm_in),
  .supply_above_lockout(supply_above_lockout), .regulator_above_70pct(regulator_above_70pct),
  .temp_above_trip(temp_above_trip), .temp_below_release(temp_below_release),
  .drive_out(drive_out), .pwm_div_out(pwm_div_out)
);

//--- testbench/tb_haptic_drive_control_regs.sv
// Self-checking bench for the haptic drive control register bank
`timescale 1ns/1ps
`include "hdc_regs.svh"
`define CHK(what, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", what, e, g); \
    end \
  end
module tb_haptic_drive_control_regs import hdc_pkg::*; ();
  logic           sys_clk = 1'b0;
  logic           reset = 1'b1;
  logic           pwm_in = 1'b0;
  logic           motor_enable_pin = 1'b1;
  logic           supply_ok = 1'b1;
  logic           reg_ok = 1'b1;
  logic           hot = 1'b0;
  logic           cool = 1'b1;
  logic           scl_pin, sda_rel, sda_out, sda_oe_n, pwm_div_out;
  wire logic      sda_wire;
  hdc_drive_out_t drive_out;
  int             fails = 0;
  int             checks = 0;
  int             n;
  logic [7:0]     dflt_q [3] = '{8'h90, 8'h2C, 8'h0E};
  logic [3:0]     flag_q [4] = '{4'b1101, 4'b0101, 4'b1001, 4'b1110};
  logic [7:0]     stat_q [4] = '{8'h0E, 8'h06, 8'h0A, 8'h0C};
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Open drain with pull-up
  assign sda_wire = sda_rel & (sda_oe_n | sda_out);
  // PWM half period in clocks; one keeps the divider runs short
  int             pwm_half = 1;
  int             pwm_cnt = 0;
  always @(negedge sys_clk) begin
    if (pwm_cnt + 1 >= pwm_half) begin
      pwm_cnt <= 0;
      pwm_in  <= ~pwm_in;
    end else begin
      pwm_cnt <= pwm_cnt + 1;
    end
  end
  hdc_regs_top dut_u (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl_pin), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .motor_enable_pin(motor_enable_pin),
    .pwm_in(pwm_in), .supply_above_lockout(supply_ok), .regulator_above_70pct(reg_ok),
    .temp_above_trip(hot), .temp_below_release(cool), .drive_out(drive_out),
    .pwm_div_out(pwm_div_out)
  );
  hdc_host_model host_u (
    .sys_clk(sys_clk), .sda_wire(sda_wire), .scl_pin(scl_pin), .sda_rel(sda_rel)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask : settle
  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b, input int c);
    host_u.dat[0] = a;
    host_u.dat[1] = b;
    host_u.transfer(`HDC_DEV_ADDR, p, 1'b0, c);
  endtask : wr
  task automatic rd(input logic [7:0] p, input int c);
    host_u.transfer(`HDC_DEV_ADDR, p, 1'b1, c);
  endtask : rd
  task automatic lvl(input logic v, inout int c);
    while (pwm_div_out !== v && c < 4000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : lvl
  // Second full period, since a mode change may cut the first short
  task automatic span(output int c);
    c = 0;
    lvl(1'b0, c);
    lvl(1'b1, c);
    lvl(1'b0, c);
    lvl(1'b1, c);
    c = 0;
    lvl(1'b0, c);
    lvl(1'b1, c);
  endtask : span
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge sys_clk);
    fails++;
    results();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    settle();
    `CHK("drive_out", 11'h497, drive_out)
    rd(`HDC_OFS_DRIVE, 3);
    `CHK("addr_ack", 1'b0, host_u.addr_ack)
    for (int i = 0; i < 3; i++) begin
      `CHK("default", dflt_q[i], host_u.dat[i])
    end
    wr(`HDC_OFS_DRIVE, 8'hFF, 8'hFF, 2);
    rd(`HDC_OFS_DRIVE, 2);
    `CHK("drive_control", 8'hF3, host_u.dat[0])
    `CHK("level_control", 8'hFC, host_u.dat[1])
    `CHK("drive_out", 11'h7FE, drive_out)
    wr(`HDC_OFS_DRIVE, 8'h60, 8'h00, 1);
    `CHK("drive_out", 11'h07E, drive_out)
    wr(`HDC_OFS_STATUS, 8'hFF, 8'hFF, 2);
    rd(`HDC_OFS_STATUS, 2);
    `CHK("health_status", 8'h0E, host_u.dat[0])
    `CHK("unmapped", 8'h00, host_u.dat[1])
    wr(`HDC_OFS_DRIVE, 8'h90, 8'h2C, 2);
    for (int k = 0; k < 4; k++) begin
      {supply_ok, reg_ok, hot, cool} = flag_q[k];
      settle();
      rd(`HDC_OFS_STATUS, 1);
      `CHK("health_status", stat_q[k], host_u.dat[0])
    end
    `CHK("drive_on", 1'b0, drive_out.drive_on)
    hot = 1'b0;
    rd(`HDC_OFS_DRIVE, 2);
    `CHK("kept", 8'h90, host_u.dat[0])
    `CHK("drive_on", 1'b0, drive_out.drive_on)
    cool = 1'b1;
    settle();
    `CHK("drive_on", 1'b1, drive_out.drive_on)
    host_u.transfer(7'h07, `HDC_OFS_DRIVE, 1'b1, 1);
    `CHK("addr_ack", 1'b1, host_u.addr_ack)
    `CHK("silent", 8'hFF, host_u.dat[0])
    // Kick with the pin low, then brake while running
    motor_enable_pin = 1'b0;
    wr(`HDC_OFS_DRIVE, 8'hF0, 8'h00, 1);
    `CHK("kick", 4'h7, drive_out[10:7])
    motor_enable_pin = 1'b1;
    settle();
    `CHK("kick", 4'hF, drive_out[10:7])
    wr(`HDC_OFS_DRIVE, 8'hD0, 8'h00, 1);
    `CHK("brake", 4'hD, drive_out[10:7])
    for (int k = 0; k < 5; k++) begin
      wr(`HDC_OFS_DRIVE, (k == 4) ? 8'h93 : {6'h20, 2'(k)}, 8'h00, 1);
      span(n);
      `CHK("pwm_period", (k % 4 == 0) ? 2 : 2 << (6 + k), n)
    end
    // 50 kHz, top of the host's allowed range
    pwm_half = 500;
    span(n);
    `CHK("pwm_in_range", 1000, n)
    results();
  end
endmodule : tb_haptic_drive_control_regs
